// ===== inc/can_line_pkg.sv
// constants, register map and carrier types of the CAN bus line front end
// What this block does, and what its host and software must do
// (RL1) while initialization is asserted, all logic and the line configuration reset
// (RL2) on power up, host holds initialization asserted at least 1 ms; the bench holds it 8 cycles
// (RL3) on warm reset, host holds initialization asserted at least 1 ms; the bench holds it one cycle
// (RL4) bypass clear: received level comes from comparing positive and negative inputs
// (RL5) positive above negative reads recessive; negative above positive reads dominant
// (RL6) bypass set: comparison off, positive input alone is the received level
// (RL7) software keeps receive option bit zero whenever it sets bypass
// (RL8) after reset bypass is clear, so both inputs feed the comparator
// (RL9) recessive drives out a high, out b low; dominant the reverse
// (RL10) selected received level passes a two-stage synchronizer before use
package can_line_pkg;
	// register indices as printed; byte address is four times the index
	localparam logic [7:0] BUS_LINE_CONFIG_IDX = 8'h2f;
	localparam logic [7:0] LINE_STATUS_IDX = 8'h30;
	localparam logic [9:0] BUS_LINE_CONFIG_ADDR = {BUS_LINE_CONFIG_IDX, 2'h0};
	localparam logic [9:0] LINE_STATUS_ADDR = {LINE_STATUS_IDX, 2'h0};
	// field positions of bus_line_config
	localparam int COMPARATOR_BYPASS_BIT = 6;
	localparam int RX_INPUT_OPTION0_BIT = 3;
	localparam logic [7:0] BUS_LINE_CONFIG_RESET = 8'h00;
	// field positions of line_status
	localparam int STAT_RX_BIT = 0;
	localparam int STAT_TX_BIT = 1;
	localparam int STAT_BYPASS_BIT = 2;
	// ahb encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'h0;
	// least hold of the initialization input, kept for reference; the bench does not use it
	localparam int CLK_PERIOD_PS = 4000;
	localparam longint RESET_MIN_PS = 64'd1000000000;
	localparam int RESET_MIN_CYCLES = int'((RESET_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	// bus level values
	localparam logic LEVEL_RECESSIVE = 1'h1;
	localparam logic LEVEL_DOMINANT = 1'h0;

	typedef struct packed {
		logic bus_in_pos;
		logic bus_in_neg;
	} line_sense_t;

	typedef struct packed {
		logic bus_out_a;
		logic bus_out_b;
	} line_drive_t;
endpackage : can_line_pkg

// ===== logic/level_sync.sv
// two-stage synchronizer for one level
`timescale 1ns/1ps
module level_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic reset_level,
	input wire logic level_in,
	output logic level_out
);
	logic meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= 1'h1;
			level_out <= 1'h1;
		end else begin
			meta_reg <= level_in;
			level_out <= meta_reg;
		end
	end

	// reset value is fixed at recessive; the port only documents it
	logic unused_reset_level;
	assign unused_reset_level = reset_level;
endmodule : level_sync

// ===== logic/can_bus_line_frontend.sv
// CAN bus line front end: receive selection, transmit drive, ahb-lite registers
`timescale 1ns/1ps
module can_bus_line_frontend (
	input wire logic clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire can_line_pkg::line_sense_t line_in,
	output can_line_pkg::line_drive_t line_out,
	input wire logic tx_bit,
	output logic rx_bit
);
	import can_line_pkg::*;

	// register state
	logic [7:0] bus_line_config_reg;
	logic wr_pend_reg;
	logic [9:0] wr_addr_reg;
	logic held_level_reg;
	// combinational helpers
	logic raw_level;
	logic bypass;
	logic addr_phase;
	logic cfg_write;
	logic [7:0] cfg_next;
	logic [31:0] rd_next;

	assign bypass = bus_line_config_reg[COMPARATOR_BYPASS_BIT];

	// zero wait states: every transfer completes in its first data-phase cycle
	assign hreadyout = 1'h1;
	assign hresp = HRESP_OKAY;
	assign addr_phase = hsel && (htrans == HTRANS_NONSEQ) && hready;
	assign cfg_write = wr_pend_reg && (wr_addr_reg == BUS_LINE_CONFIG_ADDR);
	assign cfg_next = hwdata[7:0];

	// address phase capture; only writes need remembering for the data phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_pend_reg <= 1'h0;
			wr_addr_reg <= 10'h000;
		end else begin
			// upper address bits must be zero, otherwise a write aliases onto config
			wr_pend_reg <= addr_phase && hwrite && (haddr[31:10] == 22'h000000);
			wr_addr_reg <= haddr[9:0];
		end
	end

	// line configuration; cleared by reset so the comparator is in use [RL1] [RL8]
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus_line_config_reg <= BUS_LINE_CONFIG_RESET;
		end else if (cfg_write) begin
			bus_line_config_reg <= cfg_next;
		end
	end

	// read data formed at the address phase; a write still in its data phase
	// is forwarded so that a read straight after it sees the new value
	always_comb begin
		rd_next = 32'h0000_0000;
		if (haddr[31:10] == 22'h000000) begin
			unique case (haddr[9:0])
				BUS_LINE_CONFIG_ADDR: begin
					rd_next[7:0] = cfg_write ? cfg_next : bus_line_config_reg;
				end
				LINE_STATUS_ADDR: begin
					rd_next[STAT_RX_BIT] = rx_bit;
					rd_next[STAT_TX_BIT] = tx_bit;
					rd_next[STAT_BYPASS_BIT] = bypass;
				end
				default: begin
					rd_next = 32'h0000_0000;
				end
			endcase
		end
	end

	// unmapped addresses read zero and ignore writes
	// hrdata is only reloaded by a read, so it stands through any following idle cycles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			hrdata <= rd_next;
		end
	end

	// receive level selection; with bypass clear, equal inputs give no decision, so hold the last one
	// an undriven pair idles with equal inputs, so holding avoids a false edge there
	always_comb begin
		if (bypass) begin
			raw_level = line_in.bus_in_pos; // [RL6]
		end else if (line_in.bus_in_pos && !line_in.bus_in_neg) begin
			raw_level = LEVEL_RECESSIVE; // [RL4] [RL5]
		end else if (line_in.bus_in_neg && !line_in.bus_in_pos) begin
			raw_level = LEVEL_DOMINANT; // [RL5]
		end else begin
			raw_level = held_level_reg;
		end
	end

	// last decided level, kept for the no-decision case
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			held_level_reg <= LEVEL_RECESSIVE;
		end else begin
			held_level_reg <= raw_level;
		end
	end

	// the line is asynchronous to clk, so the selected level is synchronized [RL10]
	level_sync rx_sync (
		.clk(clk),
		.rst(rst),
		.reset_level(LEVEL_RECESSIVE),
		.level_in(raw_level),
		.level_out(rx_bit)
	);

	// transmit drive from flip-flops; reset leaves the line recessive [RL9]
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			line_out.bus_out_a <= 1'h1;
			line_out.bus_out_b <= 1'h0;
		end else begin
			line_out.bus_out_a <= tx_bit;
			line_out.bus_out_b <= !tx_bit;
		end
	end

	// hsize is always a word here; narrower sizes are treated as whole words
	logic [2:0] unused_hsize;
	assign unused_hsize = hsize;

	// checks
	// every attempt opens only where reset was already low at its sampling edge;
	// disable iff alone misses a one-cycle pulse that rises and falls between
	// two edges, because the flops still show reset values afterwards
	sequence cmp_recessive;
		!rst && !bypass && line_in.bus_in_pos && !line_in.bus_in_neg;
	endsequence

	sequence cmp_dominant;
		!rst && !bypass && line_in.bus_in_neg && !line_in.bus_in_pos;
	endsequence

	sequence cmp_tie;
		!rst && !bypass && (line_in.bus_in_pos == line_in.bus_in_neg);
	endsequence

	sequence byp_pos;
		!rst && bypass;
	endsequence

	// a read of the configuration word with no write in flight to forward
	sequence cfg_read;
		!rst && addr_phase && !hwrite && !cfg_write &&
			(haddr == {22'h000000, BUS_LINE_CONFIG_ADDR});
	endsequence

	// a read of the status word
	sequence status_read;
		!rst && addr_phase && !hwrite && (haddr == {22'h000000, LINE_STATUS_ADDR});
	endsequence

	AST_RESET_CFG: assert property (@(posedge clk) $fell(rst) |-> // [RL1] [RL8]
		bus_line_config_reg == BUS_LINE_CONFIG_RESET)
		else $error("line configuration not cleared by reset");

	AST_CMP_REC: assert property (@(posedge clk) disable iff (rst) cmp_recessive |-> ##2 rx_bit) // [RL5]
		else $error("recessive comparison not seen on rx_bit");

	AST_CMP_DOM: assert property (@(posedge clk) disable iff (rst) cmp_dominant |-> ##2 !rx_bit) // [RL4]
		else $error("dominant comparison not seen on rx_bit");

	AST_CMP_HOLD: assert property (@(posedge clk) disable iff (rst) // [RL4]
		cmp_recessive ##1 cmp_tie |-> ##2 rx_bit)
		else $error("tied inputs did not hold the last level");

	AST_BYPASS_POS: assert property (@(posedge clk) disable iff (rst) // [RL6]
		byp_pos |-> ##2 rx_bit == $past(line_in.bus_in_pos, 2))
		else $error("bypass did not follow the positive input");

	// two clean edges are needed before the two stages hold line data again
	AST_SYNC_DELAY: assert property (@(posedge clk) disable iff (rst) // [RL10]
		!rst && !$past(rst) && !$past(rst, 2) |-> rx_bit == $past(raw_level, 2))
		else $error("rx_bit is not the level two cycles back");

	AST_TX_DRIVE: assert property (@(posedge clk) disable iff (rst) // [RL9]
		!rst |=> (line_out.bus_out_a == $past(tx_bit)) &&
			(line_out.bus_out_b == !$past(tx_bit)))
		else $error("transmit outputs do not match the bit");

	AST_CFG_WRITE: assert property (@(posedge clk) disable iff (rst) // [RL4] [RL6]
		cfg_write |=> bypass == $past(hwdata[COMPARATOR_BYPASS_BIT]))
		else $error("configuration write did not reach bypass");

	// reset leaves the receive side recessive and the transmit pair recessive
	AST_RESET_LINE: assert property (@(posedge clk) $fell(rst) |-> // [RL1]
		rx_bit == LEVEL_RECESSIVE && line_out.bus_out_a && !line_out.bus_out_b)
		else $error("line outputs not recessive after reset");

	// the two transmit outputs never agree once reset is gone
	AST_TX_COMPL: assert property (@(posedge clk) disable iff (rst) // [RL9]
		!rst |-> line_out.bus_out_a != line_out.bus_out_b)
		else $error("transmit outputs agree");

	// a configuration read returns the stored bypass setting in its data phase
	AST_CFG_READ: assert property (@(posedge clk) disable iff (rst) // [RL6]
		cfg_read |=> hrdata[COMPARATOR_BYPASS_BIT] == $past(bypass))
		else $error("configuration read lost the bypass bit");

	// the status word carries bypass and the synchronized level
	AST_STATUS_READ: assert property (@(posedge clk) disable iff (rst) // [RL10]
		status_read |=> hrdata[STAT_BYPASS_BIT] == $past(bypass) &&
			hrdata[STAT_RX_BIT] == $past(rx_bit))
		else $error("status read does not match the line state");
endmodule : can_bus_line_frontend

// ===== bench/can_transceiver_model.sv
// transceiver and bus line model facing the front end
`timescale 1ns/1ps
module can_transceiver_model (
	input wire can_line_pkg::line_drive_t drive,
	input wire logic remote_dom,
	input wire logic single_ended,
	output can_line_pkg::line_sense_t sense
);
	import can_line_pkg::*;
	logic dom;
	// wired bus: any dominant driver wins over recessive
	assign dom = remote_dom | (drive.bus_out_a == 1'b0 && drive.bus_out_b == 1'b1);
	// single-ended wiring leaves neg unconnected and pulled low; a design still
	// comparing then sees a tie for every dominant bit and never reads dominant
	assign sense.bus_in_pos = ~dom;
	assign sense.bus_in_neg = single_ended ? 1'b0 : dom;
endmodule : can_transceiver_model

// ===== bench/can_bus_line_frontend_tb.sv
// self-checking bench for the CAN bus line front end
`timescale 1ns/1ps
module can_bus_line_frontend_tb;
	import can_line_pkg::*;
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, tx_bit = 1, remote_dom = 0, single_ended = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, rx_bit, d;
	line_sense_t line_in;
	line_drive_t line_out;
	int mismatches = 0, check_count = 0;

	can_bus_line_frontend uut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.line_in(line_in), .line_out(line_out), .tx_bit(tx_bit), .rx_bit(rx_bit));
	can_transceiver_model far (.drive(line_out), .remote_dom(remote_dom),
		.single_ended(single_ended), .sense(line_in));

	// clock: 4 ns period
	always #2 clk = ~clk;

	function automatic logic exp_rx(input logic dom);
		return dom ? LEVEL_DOMINANT : LEVEL_RECESSIVE;
	endfunction : exp_rx

	task automatic report_and_stop();
		if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// one single ahb-lite transfer; waits on hready rather than assuming zero wait states
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1; haddr <= a; htrans <= HTRANS_NONSEQ; hwrite <= w;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask : xfer

	// random far-end levels; new level must not show after one edge, must after two
	task automatic rx_loop();
		logic prev_dom;
		// let the local drive and any mode change settle through both stages
		repeat (3) @(posedge clk);
		prev_dom = remote_dom;
		for (int i = 0; i < 12; i++) begin
			d = (i < 2) ? ~i[0] : 1'($urandom);
			@(posedge clk);
			remote_dom <= d;
			@(posedge clk);
			#1 chk({31'h0, rx_bit}, {31'h0, exp_rx(prev_dom)});
			@(posedge clk);
			#1 chk({31'h0, rx_bit}, {31'h0, exp_rx(d)});
			prev_dom = d;
		end
	endtask : rx_loop

	// hang guard, far beyond the roughly 150 cycles the tests need
	initial begin
		repeat (3000) @(posedge clk);
		mismatches++;
		report_and_stop();
	end

	initial begin
		void'($urandom(32'h59fb7a64));
		repeat (4) @(posedge clk);
		#1 chk({29'h0, line_out, rx_bit}, 32'h5);
		// 8 cycles stand in for the 1 ms minimum hold
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		xfer(1'b0, {22'h0, BUS_LINE_CONFIG_ADDR}, 32'h0);
		chk(rd, 32'h0);
		for (int i = 0; i < 12; i++) begin
			d = (i < 2) ? i[0] : 1'($urandom);
			@(posedge clk);
			tx_bit <= d;
			@(posedge clk);
			#1 chk({30'h0, line_out}, {30'h0, d, ~d});
		end
		@(posedge clk);
		tx_bit <= 1'b1;
		rx_loop();
		// comparator mode with neg pulled low: recessive, then a tie must hold it
		@(posedge clk);
		single_ended <= 1'b1;
		remote_dom <= 1'b0;
		repeat (3) @(posedge clk);
		remote_dom <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk({31'h0, rx_bit}, {31'h0, LEVEL_RECESSIVE});
		// bypass with the receive option bit left zero
		xfer(1'b1, {22'h0, BUS_LINE_CONFIG_ADDR}, 32'h1 << COMPARATOR_BYPASS_BIT);
		single_ended <= 1'b1;
		xfer(1'b0, {22'h0, BUS_LINE_CONFIG_ADDR}, 32'h0);
		chk(rd, 32'h40);
		rx_loop();
		// upper address bits set: the write must not alias onto the configuration
		xfer(1'b1, 32'h0000_04bc, 32'h0);
		xfer(1'b0, {22'h0, BUS_LINE_CONFIG_ADDR}, 32'h0);
		chk(rd, 32'h1 << COMPARATOR_BYPASS_BIT);
		// status word: bypass, transmit bit and synchronized receive level
		xfer(1'b0, {22'h0, LINE_STATUS_ADDR}, 32'h0);
		chk(rd, {29'h0, 1'b1, tx_bit, exp_rx(remote_dom)});
		xfer(1'b0, 32'h100, 32'h0);
		chk(rd, 32'h0);
		// reset in mid-run must clear bypass again
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		single_ended <= 1'b0;
		xfer(1'b0, {22'h0, BUS_LINE_CONFIG_ADDR}, 32'h0);
		chk(rd, 32'h0);
		report_and_stop();
	end
endmodule : can_bus_line_frontend_tb
